/* hw/lsfs_top.sv */
// Contract
// - Blanking of 10.5 ms applies only to forward overcurrent, never to other faults.
// - Blanking timer starts when closed-switch voltage exceeds the fault assert voltage.
// - Overcurrent clearing before blanking ends resets timer; switch stays closed, flag released.
// - Overcurrent outlasting blanking pulls the flag low and opens the switch.
// - Autoretry: 661.5 ms retry starts right after blanking, switch open, flag low.
// - Autoretry: after retry reclose for another blanking; repeat while fault persists.
// - Autoretry: overcurrent gone at a retry check leaves switch closed, flag released.
// - Latchoff: switch stays open until enable toggles low then high, or reset.
// - Reverse current opens the switch and asserts the flag at once, no blanking.
// - Over temperature opens switch and asserts flag at once; recloses after cooling.
// - Input overvoltage opens switch and asserts flag at once, no blanking.
// - Input undervoltage opens the switch while the flag stays released.
// - Switch recloses by itself once the supply returns into range.
// - Enable low keeps switch open and releases the flag pulldown.
// - Limit select low gives 200 mA limit, high gives 400 mA.
// - Flag is open drain: pulled low for a fault, otherwise undriven.
// - Flag stays asserted during the whole autoretry cycling, blanking included.
`timescale 1ns/100ps
`include "lsfs_defines.svh"

module lsfs_top #(
  parameter bit          AUTORETRY    = 1'b1,
  parameter int unsigned BLANK_CYCLES = `LSFS_BLANK_CYCLES,
  parameter int unsigned RETRY_CYCLES = `LSFS_RETRY_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Host pins
  input  wire logic        enable,
  input  wire logic        limit_select,
  input  wire logic        fault_flag_i,
  output logic             fault_flag_o,
  output logic             fault_flag_oe_n,
  // Analog comparators
  input  wire logic        overcurrent,
  input  wire logic        reverse_detect,
  input  wire logic        over_temp,
  input  wire logic        overvoltage_lockout,
  input  wire logic        undervoltage_lockout,
  // Power switch and limit
  output logic             switch_close,
  output logic             limit_high,
  // Interrupt
  output logic             irq
);

  if (BLANK_CYCLES < 1 || RETRY_CYCLES < 1) begin : g_check
    $error("lsfs_top: interval counts must be at least one cycle");
  end

  function automatic logic addr_known(input logic [31:0] addr);
    addr_known = (addr == `LSFS_OFS_CTRL) || (addr == `LSFS_OFS_STATUS) ||
                 (addr == `LSFS_OFS_IRQ_STATUS) || (addr == `LSFS_OFS_IRQ_MASK);
  endfunction

  // Input synchronisers
  lsfs_pkg::lsfs_sense_t sense_raw;
  lsfs_pkg::lsfs_sense_t sense_meta;
  lsfs_pkg::lsfs_sense_t sense;
  lsfs_pkg::lsfs_sense_t sense_prev;
  logic                  pin_meta;
  logic                  pin_sync;

  assign sense_raw = '{undervoltage_lockout: undervoltage_lockout,
                       overvoltage_lockout:  overvoltage_lockout,
                       over_temp:            over_temp,
                       reverse_detect:       reverse_detect,
                       overcurrent:          overcurrent,
                       limit_select:         limit_select,
                       enable:               enable};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_meta <= '0;
      sense      <= '0;
      sense_prev <= '0;
      pin_meta   <= 1'b1;
      pin_sync   <= 1'b1;
    end else begin
      sense_meta <= sense_raw;
      sense      <= sense_meta;
      sense_prev <= sense;
      pin_meta   <= fault_flag_i;
      pin_sync   <= pin_meta;
    end
  end

  // Registers
  logic [31:0]               ctrl;
  logic [`LSFS_EV_WIDTH-1:0] irq_status;
  logic [`LSFS_EV_WIDTH-1:0] irq_mask;

  // Fault conditions
  logic en_eff;
  logic imm_fault;
  logic lockout;

  assign en_eff    = sense.enable && ctrl[`LSFS_CTRL_SW_EN_BIT];
  assign imm_fault = sense.reverse_detect || sense.over_temp ||
                     sense.overvoltage_lockout;
  assign lockout   = imm_fault || sense.undervoltage_lockout;

  // Sequencer
  lsfs_pkg::lsfs_state_t state;
  lsfs_pkg::lsfs_state_t next_state;
  logic [31:0]           timer;
  logic                  cycling;
  logic                  blank_done;
  logic                  retry_done;

  assign blank_done = (timer == BLANK_CYCLES - 32'd1);
  assign retry_done = (timer == RETRY_CYCLES - 32'd1);

  always_comb begin
    next_state = state;
    if (!en_eff) begin
      next_state = lsfs_pkg::LSFS_OFF;
    end else begin
      case (state)
        lsfs_pkg::LSFS_OFF: begin
          next_state = lsfs_pkg::LSFS_ON;
        end
        lsfs_pkg::LSFS_ON: begin
          if (sense.overcurrent && !lockout && switch_close) begin
            next_state = lsfs_pkg::LSFS_BLANK;
          end
        end
        lsfs_pkg::LSFS_BLANK: begin
          if (lockout || !sense.overcurrent) begin
            next_state = lsfs_pkg::LSFS_ON;
          end else if (blank_done) begin
            next_state = AUTORETRY ? lsfs_pkg::LSFS_RETRY : lsfs_pkg::LSFS_LATCHED;
          end
        end
        lsfs_pkg::LSFS_RETRY: begin
          if (retry_done) begin
            next_state = lsfs_pkg::LSFS_BLANK;
          end
        end
        lsfs_pkg::LSFS_LATCHED: begin
          next_state = lsfs_pkg::LSFS_LATCHED;
        end
        default: begin
          next_state = lsfs_pkg::LSFS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= lsfs_pkg::LSFS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Interval timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer <= 32'h0000_0000;
    end else if (next_state != state) begin
      timer <= 32'h0000_0000;
    end else begin
      timer <= timer + 32'd1;
    end
  end

  // Autoretry cycling marker
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cycling <= 1'b0;
    end else if (!en_eff) begin
      cycling <= 1'b0;
    end else if (state == lsfs_pkg::LSFS_BLANK && blank_done && sense.overcurrent && !lockout) begin
      cycling <= 1'b1;
    end else if (state == lsfs_pkg::LSFS_BLANK && !sense.overcurrent && !lockout) begin
      cycling <= 1'b0;
    end
  end

  // Switch and flag drive
  logic next_switch;
  logic next_flag;

  assign next_switch = en_eff && !lockout &&
                       (next_state == lsfs_pkg::LSFS_ON || next_state == lsfs_pkg::LSFS_BLANK);
  assign next_flag   = en_eff && (imm_fault ||
                       next_state == lsfs_pkg::LSFS_RETRY ||
                       next_state == lsfs_pkg::LSFS_LATCHED ||
                       (cycling && next_state == lsfs_pkg::LSFS_BLANK));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_close    <= 1'b0;
      fault_flag_o    <= 1'b0;
      fault_flag_oe_n <= 1'b1;
      limit_high      <= 1'b0;
    end else begin
      switch_close    <= next_switch;
      fault_flag_o    <= 1'b0;
      fault_flag_oe_n <= !next_flag;
      limit_high      <= sense.limit_select;
    end
  end

  // Interrupt events
  logic [`LSFS_EV_WIDTH-1:0] events;
  logic                      status_read;

  assign events[`LSFS_EV_FORWARD]   = state == lsfs_pkg::LSFS_BLANK &&
                                      (next_state == lsfs_pkg::LSFS_RETRY ||
                                       next_state == lsfs_pkg::LSFS_LATCHED);
  assign events[`LSFS_EV_REVERSE]   = sense.reverse_detect && !sense_prev.reverse_detect;
  assign events[`LSFS_EV_THERMAL]   = sense.over_temp && !sense_prev.over_temp;
  assign events[`LSFS_EV_OVERVOLT]  = sense.overvoltage_lockout && !sense_prev.overvoltage_lockout;
  assign events[`LSFS_EV_UNDERVOLT] = sense.undervoltage_lockout && !sense_prev.undervoltage_lockout;

  // Sticky status; a new event wins over the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else if (status_read) begin
      irq_status <= events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Bus write path
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LSFS_RESP_OKAY;
      aw_addr       <= 32'h0000_0000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_known(aw_addr) ? `LSFS_RESP_OKAY : `LSFS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= `LSFS_CTRL_RESET;
      irq_mask <= `LSFS_IRQ_MASK_RESET;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == `LSFS_OFS_CTRL) begin
        ctrl <= {31'h0000_0000, w_data[`LSFS_CTRL_SW_EN_BIT]};
      end
      if (aw_addr == `LSFS_OFS_IRQ_MASK) begin
        irq_mask <= w_data[`LSFS_EV_WIDTH-1:0];
      end
    end
  end

  // Bus read path
  logic [31:0] status_word;
  logic [31:0] read_word;

  always_comb begin
    status_word                      = 32'h0000_0000;
    status_word[`LSFS_ST_SWITCH_BIT] = switch_close;
    status_word[`LSFS_ST_FLAG_BIT]   = !fault_flag_oe_n;
    status_word[`LSFS_ST_LIMIT_BIT]  = limit_high;
    status_word[`LSFS_ST_BLANK_BIT]  = state == lsfs_pkg::LSFS_BLANK;
    status_word[`LSFS_ST_RETRY_BIT]  = state == lsfs_pkg::LSFS_RETRY;
    status_word[`LSFS_ST_LATCH_BIT]  = state == lsfs_pkg::LSFS_LATCHED;
    status_word[`LSFS_ST_CYCLE_BIT]  = cycling;
    status_word[`LSFS_ST_SENSE_LSB +: $bits(lsfs_pkg::lsfs_sense_t)] = sense;
    status_word[`LSFS_ST_PIN_BIT]    = pin_sync;
  end

  always_comb begin
    case (s_axi_araddr)
      `LSFS_OFS_CTRL:       read_word = ctrl;
      `LSFS_OFS_STATUS:     read_word = status_word;
      `LSFS_OFS_IRQ_STATUS: read_word = {27'h000_0000, irq_status};
      `LSFS_OFS_IRQ_MASK:   read_word = {27'h000_0000, irq_mask};
      default:              read_word = 32'h0000_0000;
    endcase
  end

  assign status_read = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `LSFS_OFS_IRQ_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `LSFS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= read_word;
      s_axi_rresp   <= addr_known(s_axi_araddr) ? `LSFS_RESP_OKAY : `LSFS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* hw/lsfs_defines.svh */
`ifndef LSFS_DEFINES_SVH
`define LSFS_DEFINES_SVH

// Time base
`define LSFS_CLK_MHZ          40
`define LSFS_BLANK_US         10500
`define LSFS_RETRY_US         661500
`define LSFS_BLANK_CYCLES     (`LSFS_BLANK_US * `LSFS_CLK_MHZ)
`define LSFS_RETRY_CYCLES     (`LSFS_RETRY_US * `LSFS_CLK_MHZ)

// Register offsets
`define LSFS_OFS_CTRL         32'h0000_0000
`define LSFS_OFS_STATUS       32'h0000_0004
`define LSFS_OFS_IRQ_STATUS   32'h0000_0008
`define LSFS_OFS_IRQ_MASK     32'h0000_000C

// Control fields and reset values
`define LSFS_CTRL_SW_EN_BIT   0
`define LSFS_CTRL_RESET       32'h0000_0001
`define LSFS_IRQ_MASK_RESET   5'h00

// Status fields
`define LSFS_ST_SWITCH_BIT    0
`define LSFS_ST_FLAG_BIT      1
`define LSFS_ST_LIMIT_BIT     2
`define LSFS_ST_BLANK_BIT     3
`define LSFS_ST_RETRY_BIT     4
`define LSFS_ST_LATCH_BIT     5
`define LSFS_ST_CYCLE_BIT     6
`define LSFS_ST_SENSE_LSB     8
`define LSFS_ST_PIN_BIT       15

// Interrupt event bits
`define LSFS_EV_FORWARD       0
`define LSFS_EV_REVERSE       1
`define LSFS_EV_THERMAL       2
`define LSFS_EV_OVERVOLT      3
`define LSFS_EV_UNDERVOLT     4
`define LSFS_EV_WIDTH         5

// Bus responses
`define LSFS_RESP_OKAY        2'h0
`define LSFS_RESP_SLVERR      2'h2

`endif

/* hw/lsfs_pkg.sv */
package lsfs_pkg;

  typedef struct packed {
    logic undervoltage_lockout;
    logic overvoltage_lockout;
    logic over_temp;
    logic reverse_detect;
    logic overcurrent;
    logic limit_select;
    logic enable;
  } lsfs_sense_t;

  typedef enum logic [2:0] {
    LSFS_OFF,
    LSFS_ON,
    LSFS_BLANK,
    LSFS_RETRY,
    LSFS_LATCHED
  } lsfs_state_t;

endpackage

/* dv/lsfs_top_sva.sv */
`timescale 1ns/100ps
module lsfs_top_sva #(
  parameter bit          AUTORETRY    = 1'b1,
  parameter int unsigned BLANK_CYCLES = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins
  input wire logic enable,
  input wire logic limit_select,
  input wire logic fault_flag_o,
  input wire logic fault_flag_oe_n,
  input wire logic switch_close,
  input wire logic limit_high,
  // Comparators
  input wire logic overcurrent,
  input wire logic reverse_detect,
  input wire logic over_temp,
  input wire logic overvoltage_lockout,
  input wire logic undervoltage_lockout
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic        calm;
  logic [31:0] oc_run;
  assign calm = enable && !reverse_detect && !over_temp && !overvoltage_lockout && !undervoltage_lockout;
  // Closed-switch overcurrent run length
  always_ff @(posedge aclk) begin
    if (!aresetn || !(overcurrent && calm && switch_close)) begin
      oc_run <= 32'h0;
    end else begin
      oc_run <= oc_run + 32'h1;
    end
  end
  sequence trip_s;
    !switch_close && !fault_flag_oe_n;
  endsequence
  sequence oc_start_s;
    $rose(overcurrent) && switch_close && fault_flag_oe_n;
  endsequence
  sequence reclose_s;
    (AUTORETRY && overcurrent && calm)[*6] ##0 ($rose(switch_close) && !fault_flag_oe_n);
  endsequence
  reverse_trip_a: assert property ((reverse_detect && enable)[*8] |-> trip_s)
    else $error("reverse fault did not trip");
  thermal_trip_a: assert property ((over_temp && enable)[*8] |-> trip_s)
    else $error("thermal fault did not trip");
  overvolt_trip_a: assert property ((overvoltage_lockout && enable)[*8] |-> trip_s)
    else $error("overvoltage did not trip");
  undervolt_open_a: assert property ((undervoltage_lockout && enable)[*6] |-> !switch_close)
    else $error("undervoltage left switch closed");
  shutdown_off_a: assert property ((!enable)[*5] |-> !switch_close && fault_flag_oe_n)
    else $error("shutdown not honoured");
  open_drain_a: assert property (fault_flag_o == 1'b0)
    else $error("flag data not low");
  limit_follow_a: assert property ($stable(limit_select)[*6] |-> limit_high == limit_select)
    else $error("limit does not follow select");
  blank_hold_a: assert property (oc_start_s ##1 (calm && overcurrent)[*6] |-> switch_close)
    else $error("switch opened inside blanking");
  blank_trip_a: assert property (oc_run <= BLANK_CYCLES + 6)
    else $error("overcurrent outlasted blanking");
  retry_flag_a: assert property (reclose_s |-> ##1 (!fault_flag_oe_n)[*2])
    else $error("flag released while cycling");
endmodule

bind lsfs_top lsfs_top_sva #(.AUTORETRY(AUTORETRY), .BLANK_CYCLES(BLANK_CYCLES)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .enable(enable), .limit_select(limit_select),
  .fault_flag_o(fault_flag_o), .fault_flag_oe_n(fault_flag_oe_n), .switch_close(switch_close),
  .limit_high(limit_high), .overcurrent(overcurrent), .reverse_detect(reverse_detect),
  .over_temp(over_temp), .overvoltage_lockout(overvoltage_lockout),
  .undervoltage_lockout(undervoltage_lockout)
);

/* dv/lsfs_host_model.sv */
`timescale 1ns/100ps
module lsfs_host_model (
  // Clock
  input  wire logic aclk,
  // Host side
  input  wire logic want_on,
  output logic      enable,
  // Flag wire
  input  wire logic fault_flag_o,
  input  wire logic fault_flag_oe_n,
  output logic      flag_wire
);
  initial enable = 1'b0;
  always @(posedge aclk) enable <= want_on;
  assign flag_wire = fault_flag_oe_n ? 1'b1 : fault_flag_o;
endmodule

/* dv/lsfs_top_tb.sv */
`timescale 1ns/100ps
`include "lsfs_defines.svh"
module lsfs_top_tb;
  localparam int unsigned BLANK = 8;
  localparam int unsigned RETRY = 20;
  logic        aclk, aresetn, want_on, enable, limit_select, flag_wire;
  logic [4:0]  cmp;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        fault_flag_o, fault_flag_oe_n, switch_close, limit_high, irq, l_switch, l_oe_n;
  int          n_fail, compares, n;

  lsfs_top #(.AUTORETRY(1'b1), .BLANK_CYCLES(BLANK), .RETRY_CYCLES(RETRY)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .enable(enable), .limit_select(limit_select),
    .fault_flag_i(flag_wire), .fault_flag_o(fault_flag_o), .fault_flag_oe_n(fault_flag_oe_n),
    .overcurrent(cmp[0]), .reverse_detect(cmp[1]), .over_temp(cmp[2]),
    .overvoltage_lockout(cmp[3]), .undervoltage_lockout(cmp[4]),
    .switch_close(switch_close), .limit_high(limit_high), .irq(irq)
  );

  lsfs_top #(.AUTORETRY(1'b0), .BLANK_CYCLES(BLANK), .RETRY_CYCLES(RETRY)) u_dut_latch (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(32'h0), .s_axi_awprot(3'h0), .s_axi_awvalid(1'b0), .s_axi_awready(),
    .s_axi_wdata(32'h0), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(1'b0), .s_axi_araddr(32'h0), .s_axi_arprot(3'h0),
    .s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(1'b0), .enable(enable), .limit_select(limit_select), .fault_flag_i(1'b1),
    .fault_flag_o(), .fault_flag_oe_n(l_oe_n), .overcurrent(cmp[0]), .reverse_detect(cmp[1]),
    .over_temp(cmp[2]), .overvoltage_lockout(cmp[3]), .undervoltage_lockout(cmp[4]),
    .switch_close(l_switch), .limit_high(), .irq()
  );

  lsfs_host_model u_host (
    .aclk(aclk), .want_on(want_on), .enable(enable),
    .fault_flag_o(fault_flag_o), .fault_flag_oe_n(fault_flag_oe_n), .flag_wire(flag_wire)
  );

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wait_for(input bit sel, input logic v);
    n = 0;
    while ((sel ? flag_wire : switch_close) !== v && n < 200) begin
      @(negedge aclk);
      n++;
    end
    chk(n < 200, 1'b1);
  endtask

  task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({tb, r}, {1'b1, er});
  endtask

  task axi_rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
    logic       ta, tb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk({tb, r}, {1'b1, er});
  endtask

  task t_regs;
    axi_rd(`LSFS_OFS_CTRL, rd, `LSFS_RESP_OKAY);
    chk(rd, `LSFS_CTRL_RESET);
    axi_rd(`LSFS_OFS_IRQ_MASK, rd, `LSFS_RESP_OKAY);
    chk(rd, 32'h0);
    axi_rd(32'h0000_0010, rd, `LSFS_RESP_SLVERR);
    chk(rd, 32'h0);
    axi_wr(32'h0000_0010, 32'hFFFF_FFFF, `LSFS_RESP_SLVERR);
    axi_wr(`LSFS_OFS_IRQ_MASK, 32'h0000_0001, `LSFS_RESP_OKAY);
    axi_rd(`LSFS_OFS_STATUS, rd, `LSFS_RESP_OKAY);
    chk(rd[2:0], 3'h1);
  endtask

  task t_limit;
    for (int i = 1; i >= 0; i--) begin
      @(posedge aclk);
      limit_select <= i[0];
      repeat (6) @(negedge aclk);
      chk(limit_high, i[0]);
    end
  endtask

  task t_blank_short;
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      cmp[0] <= 1'b1;
      repeat (BLANK - 2) @(posedge aclk);
      cmp[0] <= 1'b0;
      repeat (2) @(negedge aclk);
    end
    repeat (BLANK * 2) @(negedge aclk);
    chk({switch_close, flag_wire}, 2'h3);
  endtask

  task t_immediate;
    for (int i = 1; i < 4; i++) begin
      @(posedge aclk);
      cmp[i] <= 1'b1;
      wait_for(0, 1'b0);
      chk(n <= 4, 1'b1);
      chk(flag_wire, 1'b0);
      repeat (6) @(posedge aclk);
      cmp[i] <= 1'b0;
      wait_for(0, 1'b1);
      chk(flag_wire, 1'b1);
    end
    chk(irq, 1'b0);
  endtask

  task t_undervolt;
    @(posedge aclk);
    cmp[4] <= 1'b1;
    wait_for(0, 1'b0);
    chk(flag_wire, 1'b1);
    repeat (6) @(posedge aclk);
    cmp[4] <= 1'b0;
    wait_for(0, 1'b1);
    chk(n <= 4, 1'b1);
    axi_rd(`LSFS_OFS_IRQ_STATUS, rd, `LSFS_RESP_OKAY);
    chk(rd, 32'h0000_001E);
    axi_rd(`LSFS_OFS_IRQ_STATUS, rd, `LSFS_RESP_OKAY);
    chk(rd, 32'h0);
  endtask

  task t_retry;
    @(posedge aclk);
    cmp[0] <= 1'b1;
    wait_for(0, 1'b0);
    chk(n >= BLANK && n <= BLANK + 4, 1'b1);
    chk(flag_wire, 1'b0);
    wait_for(0, 1'b1);
    chk(n, RETRY);
    chk(flag_wire, 1'b0);
    chk(irq, 1'b1);
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    chk(n, RETRY);
    @(posedge aclk);
    cmp[0] <= 1'b0;
    wait_for(1, 1'b1);
    repeat (BLANK) @(negedge aclk);
    chk(switch_close, 1'b1);
    axi_rd(`LSFS_OFS_IRQ_STATUS, rd, `LSFS_RESP_OKAY);
    chk(rd, 32'h0000_0001);
    repeat (3) @(negedge aclk);
    chk(irq, 1'b0);
    chk({l_switch, l_oe_n}, 2'h0);
  endtask

  task t_enable;
    @(posedge aclk);
    cmp[3] <= 1'b1;
    wait_for(1, 1'b0);
    @(posedge aclk);
    want_on <= 1'b0;
    wait_for(1, 1'b1);
    chk(switch_close, 1'b0);
    @(posedge aclk);
    cmp[3] <= 1'b0;
    want_on <= 1'b1;
    wait_for(0, 1'b1);
    chk({l_switch, l_oe_n}, 2'h3);
  endtask

  task give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    {aresetn, limit_select, cmp, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    want_on = 1'b1;
    n_fail = 0;
    compares = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wait_for(0, 1'b1);
    t_regs;
    t_limit;
    t_blank_short;
    t_immediate;
    t_undervolt;
    t_retry;
    t_enable;
    give_verdict;
  end

  initial begin
    #(25 * 5000);
    n_fail++;
    give_verdict;
  end
endmodule
